//--- rtl/ccr_pkg.sv
// package of constants and types for the core configuration register
`default_nettype none

package ccr_pkg;

  // ==========================================================================
  // register location in the coprocessor space
  // ==========================================================================
  localparam logic [4:0] CCR_REG_NUM = 5'h10;   // coprocessor register number
  localparam logic [2:0] CCR_REG_SEL = 3'h0;    // select within that number

  // ==========================================================================
  // field positions inside the 32-bit word
  // ==========================================================================
  localparam int POS_SECOND_REG     = 31;       // second register present
  localparam int POS_INSTR_SCRATCH  = 24;       // instruction scratch pad
  localparam int POS_DATA_SCRATCH   = 23;       // data scratch pad
  localparam int POS_USER_INSTR_EXT = 22;       // user instruction extension
  localparam int POS_SIMPLE_BYTE_EN = 21;       // simple byte enables only
  localparam int POS_MULDIV         = 20;       // multiply/divide unit kind
  localparam int POS_MERGE_LO       = 17;       // write merge mode, 2 bits
  localparam int POS_BURST          = 16;       // burst order
  localparam int POS_ENDIAN         = 15;       // endian select
  localparam int POS_ARCH_TYPE_LO   = 13;       // architecture type, 2 bits
  localparam int POS_ARCH_REV_LO    = 10;       // architecture revision, 3 bits
  localparam int POS_MEM_MGMT_LO    = 7;        // memory management type, 3 bits
  localparam int POS_POLICY_LO      = 0;        // cache policy, 3 bits

  // ==========================================================================
  // fixed field values
  // ==========================================================================
  localparam logic       VAL_SECOND_REG     = 1'h1;  // second register exists
  localparam logic       VAL_INSTR_SCRATCH  = 1'h0;  // not implemented
  localparam logic       VAL_DATA_SCRATCH   = 1'h0;  // not implemented
  localparam logic       VAL_USER_INSTR_EXT = 1'h0;  // no extensions
  localparam logic       VAL_SIMPLE_BYTE_EN = 1'h1;  // simple byte enables only
  localparam logic       VAL_MULDIV         = 1'h0;  // fast multiply/divide unit
  localparam logic [1:0] VAL_MERGE          = 2'h2;  // merging allowed
  localparam logic       VAL_BURST          = 1'h0;  // sequential bursts
  localparam logic       VAL_ENDIAN         = 1'h0;  // little endian
  localparam logic [1:0] VAL_ARCH_TYPE      = 2'h0;  // base 32-bit architecture
  localparam logic [2:0] VAL_ARCH_REV       = 3'h1;  // release two
  localparam logic [2:0] VAL_MEM_MGMT       = 3'h1;  // translation buffer unit

  // whole word after reset, used by checks
  localparam logic [31:0] CCR_RESET_WORD = 32'h8024_0482;

  // ==========================================================================
  // cache policy codes
  // ==========================================================================
  typedef enum logic [2:0] {
    CCR_WT_NOALLOC = 3'h0,   // write-through, no write allocate
    CCR_WT_ALLOC   = 3'h1,   // write-through, write allocate
    CCR_UNCACHED   = 3'h2,   // uncached
    CCR_WB_ALLOC   = 3'h3    // write-back, write allocate
  } ccr_policy_type;

  // value of the policy field after reset
  localparam logic [2:0] POLICY_RESET = 3'h2;

  // ==========================================================================
  // carriers
  // ==========================================================================
  // coprocessor move request
  typedef struct packed {
    logic        rdEn;      // move-from strobe
    logic        wrEn;      // move-to strobe
    logic [4:0]  regNum;    // register number
    logic [2:0]  regSel;    // select
    logic [31:0] wrData;    // move-to data
  } ccr_cp0_req_type;

  // decoded kernel segment attributes
  typedef struct packed {
    logic cacheable;        // accesses may hit a cache
    logic writeBack;        // write-back rather than write-through
    logic writeAlloc;       // allocate on write miss
  } ccr_attr_type;

endpackage : ccr_pkg

`default_nettype wire

//--- rtl/ccr_policy_map.sv
// folding of unused policy codes and attribute decode
`default_nettype none

module ccr_policy_map
(
  // raw code
  input  wire logic [2:0]          code,
  // folded code and its attributes
  output logic [2:0]               folded,
  output ccr_pkg::ccr_attr_type    attr
);

  // ==========================================================================
  // fold unused codes onto uncached
  // ==========================================================================
  function automatic logic [2:0] foldCode(input logic [2:0] c);
    if (c[2])
    begin
      foldCode = ccr_pkg::CCR_UNCACHED;
    end
    else
    begin
      foldCode = c;
    end
  endfunction : foldCode

  // ==========================================================================
  // attribute decode of the folded code
  // ==========================================================================
  always_comb
  begin
    folded = foldCode(code);
    attr   = '0;
    case (folded)
      ccr_pkg::CCR_WB_ALLOC:
      begin
        attr = '{cacheable: 1'b1, writeBack: 1'b1, writeAlloc: 1'b1};
      end
      ccr_pkg::CCR_WT_ALLOC:
      begin
        attr = '{cacheable: 1'b1, writeBack: 1'b0, writeAlloc: 1'b1};
      end
      ccr_pkg::CCR_WT_NOALLOC:
      begin
        attr = '{cacheable: 1'b1, writeBack: 1'b0, writeAlloc: 1'b0};
      end
      default:
      begin
        attr = '0;                      // uncached
      end
    endcase
  end

endmodule : ccr_policy_map

`default_nettype wire

//--- rtl/ccr_word_pack.sv
// assembly of the read word from fixed facts and the policy field
`default_nettype none

module ccr_word_pack
(
  // writable field
  input  wire logic [2:0]  policy,
  // assembled word
  output logic [31:0]      word
);

  // ==========================================================================
  // word assembly, unlisted bits stay zero
  // ==========================================================================
  always_comb
  begin
    word = '0;
    word[ccr_pkg::POS_SECOND_REG]     = ccr_pkg::VAL_SECOND_REG;
    word[ccr_pkg::POS_INSTR_SCRATCH]  = ccr_pkg::VAL_INSTR_SCRATCH;
    word[ccr_pkg::POS_DATA_SCRATCH]   = ccr_pkg::VAL_DATA_SCRATCH;
    word[ccr_pkg::POS_USER_INSTR_EXT] = ccr_pkg::VAL_USER_INSTR_EXT;
    word[ccr_pkg::POS_SIMPLE_BYTE_EN] = ccr_pkg::VAL_SIMPLE_BYTE_EN;
    word[ccr_pkg::POS_MULDIV]         = ccr_pkg::VAL_MULDIV;
    word[ccr_pkg::POS_MERGE_LO +: 2]  = ccr_pkg::VAL_MERGE;
    word[ccr_pkg::POS_BURST]          = ccr_pkg::VAL_BURST;
    word[ccr_pkg::POS_ENDIAN]         = ccr_pkg::VAL_ENDIAN;
    word[ccr_pkg::POS_ARCH_TYPE_LO +: 2] = ccr_pkg::VAL_ARCH_TYPE;
    word[ccr_pkg::POS_ARCH_REV_LO +: 3]  = ccr_pkg::VAL_ARCH_REV;
    word[ccr_pkg::POS_MEM_MGMT_LO +: 3]  = ccr_pkg::VAL_MEM_MGMT;
    word[ccr_pkg::POS_POLICY_LO +: 3]    = policy;
  end

endmodule : ccr_word_pack

`default_nettype wire

//--- rtl/ccr_core_config.sv
// core configuration register reached by coprocessor moves
//
// Summary of operation
// - top bit always reads one, unwritable
// - unimplemented bits always read zero
// - three-bit writable cache policy field, bits 2-0
// - unused policy codes fold onto uncached
// - simple byte-enable bit reads one
// - write merge field reads binary 10
// - burst order bit reads zero, sequential
// - little endian, type 00, revision 001
// - memory management type reads 001
// - both scratch-pad bits read zero
// - user instruction extension bit reads zero
// - multiply/divide unit bit reads zero
`default_nettype none

module ccr_core_config
(
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     nrst,
  // coprocessor move request
  input  wire ccr_pkg::ccr_cp0_req_type cp0Req,
  // move-from answer
  output logic [31:0]                   rdData,
  output logic                          rdValid,
  // kernel segment policy in force
  output logic [2:0]                    kernelSegmentCachePolicy,
  output logic                          kseg0Cacheable,
  output logic                          kseg0WriteBack,
  output logic                          kseg0WriteAlloc
);

  // ==========================================================================
  // declarations
  // ==========================================================================
  logic [2:0]            policy;            // stored policy field
  logic [2:0]            next_policy;       // its next value
  logic [31:0]           next_rdData;       // next answer word
  logic                  next_rdValid;      // next answer strobe
  logic                  next_cacheable;    // next attribute outputs
  logic                  next_writeBack;
  logic                  next_writeAlloc;
  logic                  regHit;            // request names this register
  logic                  rdHit;             // move-from of this register
  logic                  wrHit;             // move-to of this register
  logic [2:0]            foldedWrite;       // write data after folding
  logic [31:0]           packedWord;        // assembled read word
  ccr_pkg::ccr_attr_type nextAttr;          // attributes of next policy

  // ==========================================================================
  // address match
  // ==========================================================================
  // true when number and select point at this register
  function automatic logic matchReg(input logic [4:0] num, input logic [2:0] sel);
    matchReg = (num == ccr_pkg::CCR_REG_NUM) && (sel == ccr_pkg::CCR_REG_SEL);
  endfunction : matchReg

  // decode of the two strobes
  always_comb
  begin
    regHit = matchReg(cp0Req.regNum, cp0Req.regSel);
    rdHit  = cp0Req.rdEn && regHit;
    wrHit  = cp0Req.wrEn && regHit;
  end

  // ==========================================================================
  // helpers
  // ==========================================================================
  // folds the incoming write data
  // folding on the way in means software reads back the code in force,
  // not the unused code that it wrote
  ccr_policy_map u_fold
  (
    .code   (cp0Req.wrData[ccr_pkg::POS_POLICY_LO +: 3]),
    .folded (foldedWrite),
    .attr   ()
  );

  // decodes the attributes of the policy about to be stored
  ccr_policy_map u_attr
  (
    .code   (next_policy),
    .folded (),
    .attr   (nextAttr)
  );

  // builds the read word from the stored policy
  ccr_word_pack u_pack
  (
    .policy (policy),
    .word   (packedWord)
  );

  // ==========================================================================
  // next values
  // ==========================================================================
  always_comb
  begin
    // hold by default
    next_policy = policy;
    // only the policy bits of a move-to are kept
    if (wrHit)
    begin
      next_policy = foldedWrite;
    end
    // answer a move-from with the word before any same-cycle write
    next_rdValid = rdHit;
    if (rdHit)
    begin
      next_rdData = packedWord;
    end
    else
    begin
      next_rdData = '0;                   // idle bus reads zero
    end
  end

  // attribute group, kept apart from the field so that the decoder that
  // reads next_policy never feeds back into the process that drives it
  always_comb
  begin
    next_cacheable  = nextAttr.cacheable;
    next_writeBack  = nextAttr.writeBack;
    next_writeAlloc = nextAttr.writeAlloc;
  end

  // ==========================================================================
  // registers
  // ==========================================================================
  // attribute outputs leave from flops, never from the decoder itself
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      // reset: uncached, no answer pending
      policy          <= ccr_pkg::POLICY_RESET;
      rdData          <= '0;
      rdValid         <= 1'b0;
      kseg0Cacheable  <= 1'b0;
      kseg0WriteBack  <= 1'b0;
      kseg0WriteAlloc <= 1'b0;
    end
    else
    begin
      // normal update
      policy          <= next_policy;
      rdData          <= next_rdData;
      rdValid         <= next_rdValid;
      kseg0Cacheable  <= next_cacheable;
      kseg0WriteBack  <= next_writeBack;
      kseg0WriteAlloc <= next_writeAlloc;
    end
  end

  // policy in force is the stored field
  assign kernelSegmentCachePolicy = policy;

  // ==========================================================================
  // checks
  // ==========================================================================
  // field checks are gated by rdValid: rdData is forced to zero between
  // answers and would otherwise look like all facts cleared
  // top bit of every answer is one
  a_second_reg_bit:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      rdValid |-> rdData[31] == 1'b1)
    else $error("top bit of configuration answer not one");

  // unimplemented bits read zero
  a_unimpl_bits_zero:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      rdValid |-> (rdData[30:25] == 6'h00) && !rdData[19] && (rdData[6:3] == 4'h0))
    else $error("unimplemented bits not zero");

  // answer carries the field held when the read was taken
  a_policy_readback:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      rdValid |-> rdData[2:0] == $past(policy))
    else $error("policy field readback wrong");

  // legal codes are stored as written
  a_legal_code_stored:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      (wrHit && !cp0Req.wrData[2]) |=> policy == $past(cp0Req.wrData[2:0]))
    else $error("legal policy code not stored");

  // unused codes land on uncached and the attributes follow
  a_unused_code_fold:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      (wrHit && cp0Req.wrData[2]) |=> (policy == 3'h2) && !kseg0Cacheable)
    else $error("unused policy code not folded to uncached");

  // attributes always agree with the policy in force
  a_attr_consistent:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      (kseg0Cacheable == (policy != 3'h2)) && (kseg0WriteBack == (policy == 3'h3))
      && (kseg0WriteAlloc == (policy == 3'h3 || policy == 3'h1)))
    else $error("kernel segment attributes disagree with policy");

  // bus-facing facts: byte enables, unit kind, extensions, scratch pads
  a_unit_facts:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      rdValid |-> rdData[24:20] == 5'h02)
    else $error("unit presence bits wrong");

  // merge, burst and endian facts
  a_bus_style_facts:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      rdValid |-> (rdData[18:17] == 2'h2) && !rdData[16] && !rdData[15])
    else $error("merge, burst or endian bits wrong");

  // architecture and memory management facts
  a_arch_facts:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      rdValid |-> (rdData[14:13] == 2'h0) && (rdData[12:10] == 3'h1)
      && (rdData[9:7] == 3'h1))
    else $error("architecture or memory management bits wrong");

  // whole read-only part never moves, even right after a write
  a_read_only_hold:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      (wrHit ##1 rdValid) |-> rdData[31:3] == ccr_pkg::CCR_RESET_WORD[31:3])
    else $error("read-only part changed by a write");

  // field holds when nothing writes it
  a_policy_stable:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      !wrHit |=> $stable(policy))
    else $error("policy changed without a write");

  // one answer per move-from, one cycle later, none otherwise
  a_read_latency:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      rdHit |=> rdValid ##1 (rdValid == $past(rdHit)))
    else $error("answer strobe timing wrong");

  // neither scratch pad is reported
  a_scratch_pads_absent:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      rdValid |-> !rdData[24] && !rdData[23])
    else $error("scratch pad bits not zero");

  // no user instruction extension is reported
  a_user_ext_absent:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      rdValid |-> !rdData[22])
    else $error("user instruction extension bit not zero");

  // fast multiply/divide unit is reported
  a_muldiv_kind_zero:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      rdValid |-> !rdData[20])
    else $error("multiply/divide unit bit not zero");

  // simple byte enables only
  a_simple_byte_en:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      rdValid |-> rdData[21])
    else $error("simple byte enable bit not one");

  // write merging is allowed
  a_merge_allowed:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      rdValid |-> rdData[18:17] == 2'h2)
    else $error("merge mode bits wrong");

  // bursts run in sequential order
  a_burst_sequential:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      rdValid |-> !rdData[16])
    else $error("burst order bit not zero");

  // little endian is reported
  a_endian_little:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      rdValid |-> !rdData[15])
    else $error("endian bit not zero");

  // translation buffer memory management is reported
  a_mem_mgmt_type:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      rdValid |-> rdData[9:7] == 3'h1)
    else $error("memory management type wrong");

  // an unused code is never the policy in force
  a_policy_never_unused:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      !kernelSegmentCachePolicy[2])
    else $error("unused policy code in force");

  // a write on its own gives no answer
  a_write_no_answer:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      (wrHit && !rdHit) |=> !rdValid)
    else $error("answer strobe after a write");

  // answer bus reads zero between answers
  a_idle_data_zero:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      !rdValid |-> rdData == 32'h0000_0000)
    else $error("answer word not zero while idle");

endmodule : ccr_core_config

`default_nettype wire

//--- bench/ccr_core_config_tb.sv
// self-checking bench for the core configuration register
`default_nettype none

module ccr_core_config_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ========================================
  // signals
  // ========================================
  logic                     clk_sys;                   // 50 MHz system clock
  logic                     nrst;                      // synchronous, active low
  ccr_pkg::ccr_cp0_req_type cp0Req;                    // move request
  logic [31:0]              rdData;                    // answer word
  logic                     rdValid;                   // answer strobe
  logic [2:0]               kernelSegmentCachePolicy;  // policy in force
  logic                     kseg0Cacheable;            // attribute outputs
  logic                     kseg0WriteBack;
  logic                     kseg0WriteAlloc;
  int                       errors;                    // mismatches
  int                       checked;                   // comparisons made

  // fixed facts of the read word, policy field left clear
  localparam logic [31:0] FIXED_WORD = (32'h0000_0001 << 31)
    | (32'h0000_0001 << 21)
    | (32'h0000_0002 << 17)
    | (32'h0000_0001 << 10)
    | (32'h0000_0001 << 7);

  // one table row: written code and expected {folded, attributes}
  typedef struct packed {
    logic [2:0] code;   // code written
    logic [5:0] state;  // {policy, cacheable, writeBack, writeAlloc}
  } ccr_row_type;
  ccr_row_type rows [10];  // ordered so each row changes the state

  // ========================================
  // design under test
  // ========================================
  ccr_core_config dut
  (
    .clk_sys                  (clk_sys),
    .nrst                     (nrst),
    .cp0Req                   (cp0Req),
    .rdData                   (rdData),
    .rdValid                  (rdValid),
    .kernelSegmentCachePolicy (kernelSegmentCachePolicy),
    .kseg0Cacheable           (kseg0Cacheable),
    .kseg0WriteBack           (kseg0WriteBack),
    .kseg0WriteAlloc          (kseg0WriteAlloc)
  );

  // clock, half period 10 ns
  always #10 clk_sys = ~clk_sys;

  // ========================================
  // compare tasks
  // ========================================
  // whole-word results
  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkWord

  // policy field plus attribute bits
  task automatic chkState(input logic [5:0] exp);
    checked++;
    if ({kernelSegmentCachePolicy, kseg0Cacheable, kseg0WriteBack, kseg0WriteAlloc} !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time,
               {kernelSegmentCachePolicy, kseg0Cacheable, kseg0WriteBack, kseg0WriteAlloc}, exp);
    end
  endtask : chkState

  // single strobe
  task automatic chkFlag(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkFlag

  // ========================================
  // drivers
  // ========================================
  // one request, entered 2 ns after an edge and left standing until the
  // next request or idle, so no strobe is assigned twice in one time step
  task automatic req(input logic rd, input logic wr, input logic [4:0] num,
                     input logic [2:0] sel, input logic [31:0] data);
    cp0Req = '{rdEn: rd, wrEn: wr, regNum: num, regSel: sel, wrData: data};
    @(posedge clk_sys);
    #2;
  endtask : req

  // drop both strobes when no request follows at once
  task automatic idle;
    cp0Req.rdEn = 1'b0;
    cp0Req.wrEn = 1'b0;
  endtask : idle

  // write the register at its own location
  task automatic wr(input logic [31:0] data);
    req(1'b0, 1'b1, ccr_pkg::CCR_REG_NUM, ccr_pkg::CCR_REG_SEL, data);
  endtask : wr

  // read, answer one cycle later, then gone
  task automatic rdExpect(input logic [31:0] exp);
    req(1'b1, 1'b0, ccr_pkg::CCR_REG_NUM, ccr_pkg::CCR_REG_SEL, 32'h0000_0000);
    chkFlag(rdValid, 1'b1);
    chkWord(rdData, exp);
    idle();
    @(posedge clk_sys);
    #2;
    chkFlag(rdValid, 1'b0);
    chkWord(rdData, 32'h0000_0000);
  endtask : rdExpect

  // verdict and end of run
  task automatic complete_run;
    $display("counts: %0d compared, %0d mismatched", checked, errors);
    if (errors == 0 && checked > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  // ========================================
  // watchdog against a hang
  // ========================================
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    errors++;
    $display("timeout: run did not finish");
    complete_run();
  end

  // ========================================
  // main sequence
  // ========================================
  initial
  begin
    clk_sys = 1'b0;
    nrst    = 1'b0;
    cp0Req  = '0;
    errors  = 0;
    checked = 0;
    // codes 0..3 kept, 4..7 fold onto uncached
    rows = '{'{3'h3, 6'h1f}, '{3'h4, 6'h10}, '{3'h1, 6'h0d}, '{3'h5, 6'h10},
             '{3'h0, 6'h04}, '{3'h6, 6'h10}, '{3'h3, 6'h1f}, '{3'h7, 6'h10},
             '{3'h0, 6'h04}, '{3'h2, 6'h10}};
    repeat (10) @(posedge clk_sys);
    #2;
    nrst = 1'b1;
    @(posedge clk_sys);
    #2;
    // table: write with all upper bits set, check state and readback
    foreach (rows[i])
    begin
      wr({29'h1fff_ffff, rows[i].code});
      chkState(rows[i].state);
      rdExpect(FIXED_WORD | {29'h0000_0000, rows[i].state[5:3]});
    end
    $display("test done: policy code table");
    // mid-run reset restores the reset word
    wr(32'h0000_0003);
    idle();
    nrst = 1'b0;
    repeat (2) @(posedge clk_sys);
    #2;
    chkState(6'h10);
    chkFlag(rdValid, 1'b0);
    chkWord(rdData, 32'h0000_0000);
    nrst = 1'b1;
    @(posedge clk_sys);
    #2;
    rdExpect(FIXED_WORD | 32'h0000_0002);
    $display("test done: reset value");
    // requests elsewhere in the coprocessor space change nothing
    wr(32'h0000_0003);
    req(1'b0, 1'b1, 5'h0f, ccr_pkg::CCR_REG_SEL, 32'h0000_0000);
    req(1'b0, 1'b1, ccr_pkg::CCR_REG_NUM, 3'h1, 32'h0000_0000);
    chkState(6'h1f);
    req(1'b1, 1'b0, 5'h0f, ccr_pkg::CCR_REG_SEL, 32'h0000_0000);
    chkFlag(rdValid, 1'b0);
    req(1'b1, 1'b0, ccr_pkg::CCR_REG_NUM, 3'h1, 32'h0000_0000);
    chkFlag(rdValid, 1'b0);
    $display("test done: other locations");
    // read and write together: old value read, new value in force
    req(1'b1, 1'b1, ccr_pkg::CCR_REG_NUM, ccr_pkg::CCR_REG_SEL, 32'h8000_0001);
    chkFlag(rdValid, 1'b1);
    chkWord(rdData, FIXED_WORD | 32'h0000_0003);
    chkState(6'h0d);
    // back-to-back read shows the new code, top bit still one
    rdExpect(FIXED_WORD | 32'h0000_0001);
    $display("test done: read with write");
    complete_run();
  end

endmodule : ccr_core_config_tb

`default_nettype wire
